// ==== src/dmh_pkg.sv ====
package dmh_pkg;
    // ------------------------------------------------------------
    // operating modes and reference methods
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_PROF_POS = 8'h01;
    localparam logic [7:0] MODE_PROF_VEL = 8'h03;
    localparam logic [7:0] MODE_HOMING   = 8'h06;
    localparam logic [7:0] METH_NEG_LIM  = 8'h11;
    localparam logic [7:0] METH_POS_LIM  = 8'h12;
    localparam logic [7:0] METH_REF_POS  = 8'h17;
    localparam logic [7:0] METH_REF_NEG  = 8'h1b;
    localparam logic [7:0] METH_NO_MOVE  = 8'h23;
    // ------------------------------------------------------------
    // object indices and sub-indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_MODE_REQ  = 16'h6060;
    localparam logic [15:0] IDX_MODE_REP  = 16'h6061;
    localparam logic [15:0] IDX_ZERO_SHFT = 16'h607c;
    localparam logic [15:0] IDX_METHOD    = 16'h6098;
    localparam logic [15:0] IDX_SPEEDS    = 16'h6099;
    localparam logic [7:0]  SUB_FAST      = 8'h01;
    localparam logic [7:0]  SUB_CRAWL     = 8'h02;
    // ------------------------------------------------------------
    // command and state word bit positions
    // ------------------------------------------------------------
    localparam int CW_START_BIT = 4;
    localparam int CW_HALT_BIT  = 8;
    localparam int SW_DONE_BIT  = 12;
    localparam int SW_ERR_BIT   = 13;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  MODE_REQ_RST  = 8'h01;
    localparam logic [7:0]  MODE_REP_RST  = 8'h01;
    localparam logic [7:0]  METHOD_RST    = 8'h23;
    localparam logic [31:0] ZERO_SHFT_RST = 32'h0;
    localparam logic [31:0] FAST_SPD_RST  = 32'h3e8;
    localparam logic [31:0] CRAWL_SPD_RST = 32'h32;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int MODE_SWITCH_NS = 200;
    localparam int MODE_SWITCH_CYC =
        (MODE_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] MODE_SW_LAST = 4'(MODE_SWITCH_CYC - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_CRAWL} dmh_state_e;
endpackage

// ==== src/dmh_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmh_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // ------------------------------------------------------------
    // three stages, level accepted once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            dout  <= '0;
        end else if (ce) begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== src/dmh_posrep.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmh_posrep (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [31:0] act_pos,
    input  wire logic [31:0] ref_pos,
    input  wire logic [31:0] zero_shift,
    output var  logic [31:0] pos_out
);
    // ------------------------------------------------------------
    // reported position, wraps like the position counter itself
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_out <= '0;
        end else if (ce) begin
            pos_out <= act_pos - ref_pos + zero_shift;
        end
    end
endmodule
`default_nettype wire

// ==== src/dmh_drive_mode_homing.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmh_drive_mode_homing (
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    input  wire logic        OBJ_WR,
    input  wire logic        OBJ_RD,
    input  wire logic [15:0] OBJ_INDEX,
    input  wire logic [7:0]  OBJ_SUBIDX,
    input  wire logic [31:0] OBJ_WDATA,
    output var  logic        OBJ_ACK,
    output var  logic        OBJ_ERR,
    output var  logic [31:0] OBJ_RDATA,
    input  wire logic [15:0] CTRL_WORD,
    input  wire logic        NEG_LIMIT,
    input  wire logic        POS_LIMIT,
    input  wire logic        REF_SWITCH,
    input  wire logic [31:0] ACT_POS,
    output var  logic [15:0] STATE_WORD,
    output var  logic        MOVE_EN,
    output var  logic        MOVE_POS_DIR,
    output var  logic [31:0] MOVE_SPEED,
    output var  logic [31:0] REPORTED_POS
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic valid_mode(input logic [7:0] code);
        return code == dmh_pkg::MODE_PROF_POS || code == dmh_pkg::MODE_PROF_VEL
            || code == dmh_pkg::MODE_HOMING;
    endfunction

    function automatic logic valid_method(input logic [7:0] code);
        return code == dmh_pkg::METH_NEG_LIM || code == dmh_pkg::METH_POS_LIM
            || code == dmh_pkg::METH_REF_POS || code == dmh_pkg::METH_REF_NEG
            || code == dmh_pkg::METH_NO_MOVE;
    endfunction

    // switch level the method homes on: {neg, pos, ref}
    function automatic logic target_lvl(input logic [7:0] meth, input logic [2:0] sw);
        if (meth == dmh_pkg::METH_NEG_LIM) begin
            return sw[2];
        end else if (meth == dmh_pkg::METH_POS_LIM) begin
            return sw[1];
        end
        return sw[0];
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]  sw_lvl;
    logic [2:0]  sw_prev_ff;
    logic        start_prev_ff;
    logic [7:0]  mode_req_ff;
    logic [7:0]  mode_rep_ff;
    logic [3:0]  mode_cnt_ff;
    logic [7:0]  method_ff;
    logic [31:0] zero_shift_ff;
    logic [31:0] fast_spd_ff;
    logic [31:0] crawl_spd_ff;
    logic [31:0] ref_pos_ff;
    logic        done_ff;
    logic        err_ff;
    logic        dir_pos_ff;
    logic        reversed_ff;
    dmh_pkg::dmh_state_e state_ff;

    logic neg_lvl;
    logic pos_lvl;
    logic ref_lvl;
    logic busy;
    logic limit_meth;
    logic home_start;
    logic abort_err;
    logic leave_home;
    logic travel_lim;
    logic tgt_now;
    logic tgt_fall;
    logic hit_mode;
    logic hit_meth;
    logic hit_shift;
    logic hit_speed;
    logic hit_rep;
    logic wr_ok;
    logic rd_ok;

    assign neg_lvl    = sw_lvl[2];
    assign pos_lvl    = sw_lvl[1];
    assign ref_lvl    = sw_lvl[0];
    assign busy       = state_ff != dmh_pkg::ST_IDLE;
    assign limit_meth = method_ff == dmh_pkg::METH_NEG_LIM
                     || method_ff == dmh_pkg::METH_POS_LIM;
    assign home_start = !busy && mode_rep_ff == dmh_pkg::MODE_HOMING
                     && CTRL_WORD[dmh_pkg::CW_START_BIT] && !start_prev_ff;
    assign abort_err  = CTRL_WORD[dmh_pkg::CW_HALT_BIT] || (neg_lvl && pos_lvl);
    assign leave_home = mode_req_ff != dmh_pkg::MODE_HOMING;
    assign travel_lim = dir_pos_ff ? pos_lvl : neg_lvl;
    assign tgt_now    = target_lvl(method_ff, sw_lvl);
    assign tgt_fall   = target_lvl(method_ff, sw_prev_ff) && !tgt_now;

    assign hit_mode  = OBJ_INDEX == dmh_pkg::IDX_MODE_REQ;
    assign hit_rep   = OBJ_INDEX == dmh_pkg::IDX_MODE_REP;
    assign hit_shift = OBJ_INDEX == dmh_pkg::IDX_ZERO_SHFT;
    assign hit_meth  = OBJ_INDEX == dmh_pkg::IDX_METHOD;
    assign hit_speed = OBJ_INDEX == dmh_pkg::IDX_SPEEDS
                    && (OBJ_SUBIDX == dmh_pkg::SUB_FAST || OBJ_SUBIDX == dmh_pkg::SUB_CRAWL);
    assign wr_ok = (hit_mode && valid_mode(OBJ_WDATA[7:0]))
                || (hit_meth && valid_method(OBJ_WDATA[7:0]) && !busy)
                || hit_shift || hit_speed;
    assign rd_ok = hit_mode || hit_rep || hit_shift || hit_meth || hit_speed;

    // ------------------------------------------------------------
    // pin inputs and edge history
    // ------------------------------------------------------------
    dmh_sync #(
        .W (3)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .ce    (CE),
        .din   ({NEG_LIMIT, POS_LIMIT, REF_SWITCH}),
        .dout  (sw_lvl)
    );

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sw_prev_ff    <= '0;
            start_prev_ff <= 1'b0;
        end else if (CE) begin
            sw_prev_ff    <= sw_lvl;
            start_prev_ff <= CTRL_WORD[dmh_pkg::CW_START_BIT];
        end
    end

    // ------------------------------------------------------------
    // object writes
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_req_ff   <= dmh_pkg::MODE_REQ_RST;
            method_ff     <= dmh_pkg::METHOD_RST;
            zero_shift_ff <= dmh_pkg::ZERO_SHFT_RST;
            fast_spd_ff   <= dmh_pkg::FAST_SPD_RST;
            crawl_spd_ff  <= dmh_pkg::CRAWL_SPD_RST;
        end else if (CE && OBJ_WR && wr_ok) begin
            if (hit_mode) begin
                mode_req_ff <= OBJ_WDATA[7:0];
            end
            if (hit_meth) begin
                method_ff <= OBJ_WDATA[7:0];
            end
            if (hit_shift) begin
                zero_shift_ff <= OBJ_WDATA;
            end
            if (hit_speed && OBJ_SUBIDX == dmh_pkg::SUB_FAST) begin
                fast_spd_ff <= OBJ_WDATA;
            end
            if (hit_speed && OBJ_SUBIDX == dmh_pkg::SUB_CRAWL) begin
                crawl_spd_ff <= OBJ_WDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // object answers, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OBJ_ACK   <= 1'b0;
            OBJ_ERR   <= 1'b0;
            OBJ_RDATA <= '0;
        end else if (CE) begin
            OBJ_ACK <= OBJ_WR || OBJ_RD;
            OBJ_ERR <= (OBJ_WR && !wr_ok) || (OBJ_RD && !OBJ_WR && !rd_ok);
            if (OBJ_RD && !OBJ_WR) begin
                unique case (1'b1)
                    hit_mode:  OBJ_RDATA <= {24'h0, mode_req_ff};
                    hit_rep:   OBJ_RDATA <= {24'h0, mode_rep_ff};
                    hit_shift: OBJ_RDATA <= zero_shift_ff;
                    hit_meth:  OBJ_RDATA <= {24'h0, method_ff};
                    hit_speed: OBJ_RDATA <= OBJ_SUBIDX == dmh_pkg::SUB_FAST
                                            ? fast_spd_ff : crawl_spd_ff;
                    default:   OBJ_RDATA <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // mode switch-over
    // ------------------------------------------------------------
    // waits for an idle homing engine; a start landing on the last count still drives one travel cycle in the new mode
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_rep_ff <= dmh_pkg::MODE_REP_RST;
            mode_cnt_ff <= '0;
        end else if (CE) begin
            if (mode_req_ff == mode_rep_ff || busy || (OBJ_WR && hit_mode)) begin
                mode_cnt_ff <= '0;
            end else if (mode_cnt_ff == dmh_pkg::MODE_SW_LAST) begin
                mode_rep_ff <= mode_req_ff;
                mode_cnt_ff <= '0;
            end else begin
                mode_cnt_ff <= mode_cnt_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // homing engine
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff    <= dmh_pkg::ST_IDLE;
            dir_pos_ff  <= 1'b0;
            reversed_ff <= 1'b0;
            done_ff     <= 1'b0;
            err_ff      <= 1'b0;
            ref_pos_ff  <= '0;
        end else if (CE) begin
            if (busy && leave_home) begin
                state_ff <= dmh_pkg::ST_IDLE;
            end else if (busy && abort_err) begin
                err_ff   <= 1'b1;
                state_ff <= dmh_pkg::ST_IDLE;
            end else begin
                unique case (state_ff)
                    dmh_pkg::ST_IDLE: begin
                        if (home_start) begin
                            done_ff     <= 1'b0;
                            err_ff      <= 1'b0;
                            reversed_ff <= 1'b0;
                            state_ff    <= dmh_pkg::ST_FAST;
                            dir_pos_ff  <= method_ff == dmh_pkg::METH_POS_LIM
                                        || method_ff == dmh_pkg::METH_REF_POS;
                            if (method_ff == dmh_pkg::METH_NO_MOVE) begin
                                state_ff   <= dmh_pkg::ST_IDLE;
                                ref_pos_ff <= ACT_POS;
                                done_ff    <= 1'b1;
                            end
                        end
                    end
                    dmh_pkg::ST_FAST: begin
                        if (tgt_now) begin
                            state_ff   <= dmh_pkg::ST_CRAWL;
                            dir_pos_ff <= !dir_pos_ff;
                        end else if (!limit_meth && travel_lim) begin
                            if (reversed_ff) begin
                                err_ff   <= 1'b1;
                                state_ff <= dmh_pkg::ST_IDLE;
                            end else begin
                                reversed_ff <= 1'b1;
                                dir_pos_ff  <= !dir_pos_ff;
                            end
                        end
                    end
                    dmh_pkg::ST_CRAWL: begin
                        if (tgt_fall) begin
                            ref_pos_ff <= ACT_POS;
                            done_ff    <= 1'b1;
                            state_ff   <= dmh_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // motion and state word outputs
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            MOVE_EN      <= 1'b0;
            MOVE_POS_DIR <= 1'b0;
            MOVE_SPEED   <= '0;
            STATE_WORD   <= '0;
        end else if (CE) begin
            MOVE_EN      <= busy;
            MOVE_POS_DIR <= dir_pos_ff;
            MOVE_SPEED   <= state_ff == dmh_pkg::ST_FAST  ? fast_spd_ff
                          : state_ff == dmh_pkg::ST_CRAWL ? crawl_spd_ff : '0;
            STATE_WORD   <= '0;
            STATE_WORD[dmh_pkg::SW_DONE_BIT] <= done_ff;
            STATE_WORD[dmh_pkg::SW_ERR_BIT]  <= err_ff;
        end
    end

    dmh_posrep u_posrep (
        .clk        (REF_CLK),
        .rst_b      (RST_B),
        .ce         (CE),
        .act_pos    (ACT_POS),
        .ref_pos    (ref_pos_ff),
        .zero_shift (zero_shift_ff),
        .pos_out    (REPORTED_POS)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_bad_mode_wr;
        CE && OBJ_WR && hit_mode && !valid_mode(OBJ_WDATA[7:0]);
    endsequence
    sequence s_refused;
        OBJ_ACK && OBJ_ERR;
    endsequence

    property p_mode_legal;
        valid_mode(mode_req_ff) && valid_mode(mode_rep_ff);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code");

    property p_rep_after_delay;
        mode_rep_ff != $past(mode_rep_ff) |-> $past(mode_cnt_ff) == dmh_pkg::MODE_SW_LAST
            && mode_rep_ff == $past(mode_req_ff);
    endproperty
    a_rep_after_delay: assert property (p_rep_after_delay) else $error("early report");

    property p_method_legal;
        valid_method(method_ff);
    endproperty
    a_method_legal: assert property (p_method_legal) else $error("illegal method");

    property p_method_held;
        busy |=> $stable(method_ff);
    endproperty
    a_method_held: assert property (p_method_held) else $error("method changed in travel");

    property p_reject_mode;
        s_bad_mode_wr |=> s_refused and $stable(mode_req_ff);
    endproperty
    a_reject_mode: assert property (p_reject_mode) else $error("bad mode accepted");

    property p_start_clears;
        CE && home_start && method_ff != dmh_pkg::METH_NO_MOVE |=> !done_ff && !err_ff && busy;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start kept flags");

    property p_no_travel;
        CE && home_start && method_ff == dmh_pkg::METH_NO_MOVE
            |=> !busy && done_ff && ref_pos_ff == $past(ACT_POS);
    endproperty
    a_no_travel: assert property (p_no_travel) else $error("method 35 wrong");

    property p_halt_err;
        CE && busy && !leave_home && abort_err |=> err_ff && !busy;
    endproperty
    a_halt_err: assert property (p_halt_err) else $error("abort without error");

    property p_speed;
        CE && busy |=> MOVE_EN && MOVE_SPEED == ($past(state_ff) == dmh_pkg::ST_FAST
            ? $past(fast_spd_ff) : $past(crawl_spd_ff));
    endproperty
    a_speed: assert property (p_speed) else $error("wrong travel speed");

    property p_reverse;
        CE && state_ff == dmh_pkg::ST_FAST && !limit_meth && !abort_err && !leave_home
            && !tgt_now && travel_lim && !reversed_ff |=> reversed_ff && busy
            && dir_pos_ff != $past(dir_pos_ff);
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal at limit");

    property p_second_limit;
        CE && state_ff == dmh_pkg::ST_FAST && !limit_meth && !leave_home
            && !tgt_now && travel_lim && reversed_ff |=> err_ff && !busy;
    endproperty
    a_second_limit: assert property (p_second_limit) else $error("no abort at limit");

    property p_word_bits;
        CE |=> STATE_WORD[dmh_pkg::SW_DONE_BIT] == $past(done_ff)
            && STATE_WORD[dmh_pkg::SW_ERR_BIT] == $past(err_ff);
    endproperty
    a_word_bits: assert property (p_word_bits) else $error("state word stale");
endmodule
`default_nettype wire

// ==== tb/dmh_axis_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------
// axis and switches
// ----------------
module dmh_axis_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        move_en,
    input  wire logic        move_pos_dir,
    input  wire logic        both_lim,
    output var  logic [31:0] act_pos,
    output var  logic        neg_limit,
    output var  logic        pos_limit,
    output var  logic        ref_switch
);
    // one unit per cycle, speed ignored: keeps edge positions predictable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_pos <= 32'h0;
        end else if (move_en) begin
            act_pos <= move_pos_dir ? act_pos + 32'h1 : act_pos - 32'h1;
        end
    end
    // both_lim is a commanded fault, both limits at once
    always_comb begin
        neg_limit  = both_lim | ($signed(act_pos) < -20);
        pos_limit  = both_lim | ($signed(act_pos) > 20);
        ref_switch = ($signed(act_pos) > 4) && ($signed(act_pos) < 11);
    end
endmodule
`default_nettype wire

// ==== tb/dmh_drive_mode_homing_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmh_drive_mode_homing_test;
    logic        REF_CLK = 0, RST_B = 0, CE = 1, OBJ_WR = 0, OBJ_RD = 0, both = 0;
    logic        OBJ_ACK, OBJ_ERR, MOVE_EN, MOVE_POS_DIR, NEG_LIMIT, POS_LIMIT, REF_SWITCH, er;
    logic [15:0] OBJ_INDEX = 0, CTRL_WORD = 0, STATE_WORD;
    logic [7:0]  OBJ_SUBIDX = 0;
    logic [31:0] OBJ_WDATA = 0, OBJ_RDATA, ACT_POS, MOVE_SPEED, REPORTED_POS, rd;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    always #20 REF_CLK = ~REF_CLK;
    dmh_drive_mode_homing dmh_drive_mode_homing_i (.REF_CLK, .RST_B, .CE, .OBJ_WR, .OBJ_RD,
        .OBJ_INDEX, .OBJ_SUBIDX, .OBJ_WDATA, .OBJ_ACK, .OBJ_ERR, .OBJ_RDATA, .CTRL_WORD,
        .NEG_LIMIT, .POS_LIMIT, .REF_SWITCH, .ACT_POS, .STATE_WORD, .MOVE_EN, .MOVE_POS_DIR,
        .MOVE_SPEED, .REPORTED_POS);
    dmh_axis_model dmh_axis_model_i (.clk(REF_CLK), .rst_b(RST_B), .move_en(MOVE_EN),
        .move_pos_dir(MOVE_POS_DIR), .both_lim(both), .act_pos(ACT_POS),
        .neg_limit(NEG_LIMIT), .pos_limit(POS_LIMIT), .ref_switch(REF_SWITCH));
    // ----------------
    // tasks
    // ----------------
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sx,
                       input logic [31:0] d);
        @(posedge REF_CLK);
        OBJ_WR <= w;
        OBJ_RD <= !w;
        OBJ_INDEX <= ix;
        OBJ_SUBIDX <= sx;
        OBJ_WDATA <= d;
        @(posedge REF_CLK);
        OBJ_WR <= 0;
        OBJ_RD <= 0;
        #1 rd = OBJ_RDATA;
        er = OBJ_ERR;
        cmp("ack", 1, OBJ_ACK);
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] sx, input logic [31:0] d,
                      input logic e);
        acc(1, ix, sx, d);
        cmp("refused", e, er);
    endtask
    task automatic rdc(input logic [15:0] ix, input logic [7:0] sx, input logic [31:0] e);
        acc(0, ix, sx, 0);
        cmp("rdata", e, rd);
    endtask
    // settled samples only: the state word lags a new start by one cycle
    task automatic wait_sw(input int b);
        #1;
        for (int i = 0; i < 3000 && STATE_WORD[b] !== 1'b1; i++) begin
            @(posedge REF_CLK);
            #1;
        end
        cmp("state bit", 1, STATE_WORD[b]);
    endtask
    task automatic home(input logic [7:0] m);
        wr(16'h6098, 0, m, 0);
        @(posedge REF_CLK) CTRL_WORD <= 16'h0010;
        repeat (2) @(posedge REF_CLK);
        CTRL_WORD <= 16'h0000;
    endtask
    // hang guard, generous against the travel lengths of the axis model
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    // ----------------
    // sequence
    // ----------------
    initial begin
        repeat (8) @(posedge REF_CLK);
        RST_B <= 1;
        rdc(16'h6060, 0, 32'h1);
        rdc(16'h6061, 0, 32'h1);
        rdc(16'h607c, 0, 32'h0);
        rdc(16'h6098, 0, 32'h23);
        rdc(16'h6099, 1, 32'd1000);
        rdc(16'h6099, 2, 32'd50);
        wr(16'h6061, 0, 32'h3, 1);
        wr(16'h6060, 0, 32'h2, 1);
        wr(16'h6098, 0, 32'h10, 1);
        wr(16'h6060, 0, 32'h3, 0);
        // frozen clock enable must also freeze the switch-over count
        @(posedge REF_CLK) CE <= 0;
        repeat (8) @(posedge REF_CLK);
        CE <= 1;
        rdc(16'h6061, 0, 32'h1);
        repeat (8) @(posedge REF_CLK);
        rdc(16'h6061, 0, 32'h3);
        wr(16'h6060, 0, 32'h6, 0);
        repeat (8) @(posedge REF_CLK);
        rdc(16'h6061, 0, 32'h6);
        wr(16'h607c, 0, 32'h5, 0);
        home(8'h23);
        wait_sw(12);
        cmp("position", 32'h5, REPORTED_POS);
        home(8'h11);
        wait_sw(12);
        // axis coasts two units past the zero edge before it stops
        repeat (2) @(posedge REF_CLK);
        #1 cmp("position", 32'h7, REPORTED_POS);
        home(8'h12);
        wait_sw(12);
        home(8'h17);
        wait_sw(12);
        cmp("error bit", 0, STATE_WORD[13]);
        home(8'h1b);
        repeat (6) @(posedge REF_CLK);
        #1 cmp("speed", 32'd1000, MOVE_SPEED);
        cmp("direction", 0, MOVE_POS_DIR);
        wr(16'h6098, 0, 32'h11, 1);
        rdc(16'h6098, 0, 32'h1b);
        @(posedge REF_CLK) CTRL_WORD <= 16'h0100;
        wait_sw(13);
        cmp("done bit", 0, STATE_WORD[12]);
        @(posedge REF_CLK) CTRL_WORD <= 16'h0000;
        home(8'h1b);
        both <= 1;
        wait_sw(13);
        @(posedge REF_CLK) both <= 0;
        final_report();
    end
endmodule
`default_nettype wire
